/* File: bench/ahb_host.sv */
// Host model: single-word AHB-Lite master reaching the clock registers.
// Assumes hready comes straight from the one slave's hreadyout.
`timescale 1ns/1ns
`default_nettype none
module ahb_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = rtc_irq_pkg::HSIZE_WORD;
    hwdata = 32'h0;
  end
  // One transfer; called just after a rising edge, waits as long as the slave asks
  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d,
                      output logic [7:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, i, 2'h0};
    htrans <= rtc_irq_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata[7:0];
    // Released data lines show a changed pattern, never the old value
    hwdata <= ~{24'h0, d};
  endtask
  // Update enable goes down first so a period change cannot pulse the pin
  task automatic set_ext(input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, rtc_irq_pkg::IDX_INTERRUPT_CONTROL, 8'h00, q);
    xfer(1'b1, rtc_irq_pkg::IDX_EXTENSION_CONTROL, d, q);
  endtask
endmodule
`default_nettype wire

/* File: bench/rtc_irq_assertions.sv */
// Checker for the alarm and update interrupt core, bound to its ports.
// Assumes control bits change only through bus writes seen on these ports.
`timescale 1ns/1ns
`default_nettype none
module rtc_irq_chk #(
  parameter int unsigned RELEASE_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic timer_irq_req,
  input wire logic irq_n_oe_n
);
  // =====================================================================
  // Shadow of the control bits
  logic dw_q;
  logic [5:0] ix_q;
  logic [7:0] ctl_q;
  logic [7:0] ext_q;
  logic [19:0] low_q;
  wire logic fw = dw_q && ix_q == rtc_irq_pkg::IDX_EVENT_FLAGS;
  wire logic cw = dw_q && ix_q == rtc_irq_pkg::IDX_INTERRUPT_CONTROL;
  // Address phase remembered so the data phase can be decoded
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dw_q <= 1'b0;
      ix_q <= 6'h00;
    end else begin
      dw_q <= hsel && hready && htrans == rtc_irq_pkg::HTRANS_NONSEQ && hwrite;
      ix_q <= haddr[7:2];
    end
  end
  // Writes land at the end of the data phase, as in the core
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctl_q <= 8'h00;
      ext_q <= 8'h00;
    end else if (cw) begin
      ctl_q <= hwdata[7:0] & rtc_irq_pkg::MASK_INTERRUPT_CONTROL;
    end else if (dw_q && ix_q == rtc_irq_pkg::IDX_EXTENSION_CONTROL) begin
      ext_q <= hwdata[7:0] & rtc_irq_pkg::MASK_EXTENSION_CONTROL;
    end
  end
  // Length of the current low stretch on the pin
  always_ff @(posedge clk) begin
    if (!reset_n || irq_n_oe_n) begin
      low_q <= 20'h0;
    end else begin
      low_q <= low_q + 20'h1;
    end
  end
  // =====================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_upd_sec;
    sec_tick && ctl_q == 8'h20 && !ext_q[5] && !cw |=> !irq_n_oe_n;
  endproperty
  a_upd_sec: assert property (p_upd_sec) else $error("no update pulse on seconds tick");
  property p_upd_min;
    sec_tick && !min_tick && ctl_q == 8'h20 && ext_q[5] && irq_n_oe_n && !cw |=> irq_n_oe_n;
  endproperty
  a_upd_min: assert property (p_upd_min) else $error("seconds tick pulsed in minute mode");
  property p_stop;
    (sec_tick || min_tick) && ctl_q == 8'h21 && irq_n_oe_n && !cw |=> irq_n_oe_n;
  endproperty
  a_stop: assert property (p_stop) else $error("update pulse while stopped");
  property p_rel;
    ctl_q == 8'h20 && $rose(irq_n_oe_n) && !$past(dw_q) |-> low_q == RELEASE_CYCLES;
  endproperty
  a_rel: assert property (p_rel) else $error("update pulse length wrong");
  property p_clr;
    fw && !hwdata[5] && !hwdata[3] && !sec_tick && !min_tick && !ctl_q[4] && !cw
      |=> irq_n_oe_n;
  endproperty
  a_clr: assert property (p_clr) else $error("pin held after flags cleared");
  property p_en_off;
    cw && hwdata[5:3] == 3'h0 |=> irq_n_oe_n;
  endproperty
  a_en_off: assert property (p_en_off) else $error("pin held after enables cleared");
  property p_timer;
    timer_irq_req && ctl_q[4] |-> !irq_n_oe_n;
  endproperty
  a_timer: assert property (p_timer) else $error("timer request not on pin");
  property p_quiet;
    ctl_q[5:3] == 3'h0 |-> irq_n_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pin low with all enables off");
  property p_tick_only;
    ctl_q == 8'h08 && $fell(irq_n_oe_n) && !$past(dw_q) |-> $past(sec_tick);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("alarm outside seconds tick");
  c_rel: cover property (ctl_q == 8'h20 && $rose(irq_n_oe_n));
  c_timer: cover property (timer_irq_req && ctl_q[4]);
  c_alarm: cover property (ctl_q == 8'h08 && $fell(irq_n_oe_n));
endmodule
bind rtc_irq_core rtc_irq_chk #(.RELEASE_CYCLES(RELEASE_CYCLES)) rtc_irq_chk_inst (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .sec_tick(sec_tick),
  .min_tick(min_tick), .timer_irq_req(timer_irq_req), .irq_n_oe_n(irq_n_oe_n)
);
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the alarm and update interrupt core.
// Assumes a pull-up on the open-drain interrupt line.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module tb_top;
  localparam int unsigned RC = 20;
  localparam logic [5:0] FL = rtc_irq_pkg::IDX_EVENT_FLAGS;
  localparam logic [5:0] CT = rtc_irq_pkg::IDX_INTERRUPT_CONTROL;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp, sec_tick, min_tick, timer_irq_req;
  logic [31:0] haddr, hwdata, hrdata, seed, r, a, t;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] cur_sec, cur_min, cur_weekday;
  logic [5:0] cur_hour, cur_day;
  logic irq_n_out, irq_n_oe_n;
  logic [7:0] v;
  logic [5:0] ri [8] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h0d, 6'h0e, 6'h0f, 6'h3f};
  logic [7:0] rm [8] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hfb, 8'h00, 8'h3d, 8'h00};
  int n_errors, cmp_count, cyc, n;
  // Pull-up wins whenever the core lets go
  wire logic irq_line = irq_n_oe_n ? 1'b1 : irq_n_out;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  rtc_irq_core #(.RELEASE_CYCLES(RC)) rtc_irq_core_inst (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sec_tick(sec_tick), .min_tick(min_tick), .cur_sec(cur_sec),
    .cur_min(cur_min), .cur_hour(cur_hour), .cur_day(cur_day), .cur_weekday(cur_weekday),
    .timer_irq_req(timer_irq_req), .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));
  ahb_host ahb_host_inst (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // =====================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] bcd(input int x);
    return 8'(((x / 10) << 4) + x % 10);
  endfunction
  // Alarm layout {sec, min, hour, week-day}; time layout {sec, min, hour, day}
  function automatic logic exp_alarm(input logic [31:0] al, tm, input logic sel,
                                     input logic [6:0] wd);
    logic dm;
    dm = sel ? (al[5:0] == tm[5:0]) : |(al[6:0] & wd);
    return (al[31] || al[30:24] == tm[30:24]) && (al[23] || al[22:16] == tm[22:16])
      && (al[15] || al[13:8] == tm[13:8]) && (al[7] || dm);
  endfunction
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] q;
    ahb_host_inst.xfer(1'b1, i, d, q);
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] q);
    ahb_host_inst.xfer(1'b0, i, 8'h00, q);
  endtask
  // Pin is combinational, so look after the edge's updates have landed
  task automatic pin(input logic e);
    #1;
    `CHK("irq line", e, irq_line)
    @(posedge clk);
  endtask
  task automatic tick(input logic m);
    sec_tick <= 1'b1;
    min_tick <= m;
    @(posedge clk);
    sec_tick <= 1'b0;
    min_tick <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ac(input logic [7:0] c, input logic [31:0] al, input logic sel,
                    input logic [31:0] tm, input logic [6:0] wd);
    logic e;
    cur_sec <= tm[30:24];
    cur_min <= tm[22:16];
    cur_hour <= tm[13:8];
    cur_day <= tm[5:0];
    cur_weekday <= wd;
    for (int k = 0; k < 4; k++) wr(6'h06 + 6'(k), al[31 - 8 * k -: 8]);
    ahb_host_inst.set_ext({4'h0, sel, 3'h0});
    wr(CT, c);
    rd(FL, v);
    `CHK("flag before tick", 1'b0, v[3])
    tick(1'b0);
    e = exp_alarm(al, tm, sel, wd) && !c[0];
    rd(FL, v);
    `CHK("alarm flag", e, v[3])
    pin(!(e && c[3]));
    wr(FL, 8'h08);
    rd(FL, v);
    `CHK("flag after write one", e, v[3])
    wr(FL, 8'h00);
    pin(1'b1);
  endtask
  // Counting starts one cycle after the first low cycle of the pulse
  task automatic uc(input logic [7:0] c, e, input logic m, uf, input int lo);
    ahb_host_inst.set_ext(e);
    wr(CT, c);
    wr(FL, 8'h00);
    tick(m);
    n = 0;
    repeat (RC + 4) begin
      #1;
      if (irq_line === 1'b0) n++;
      @(posedge clk);
    end
    `CHK("update low cycles", lo, n)
    rd(FL, v);
    `CHK("update flag", uf, v[5])
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, well above the roughly one thousand cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  // =====================================================================
  // Main sequence
  initial begin
    seed = 32'h0000fca7;
    {reset_n, sec_tick, min_tick, timer_irq_req} = 4'h0;
    {cur_sec, cur_min, cur_hour, cur_day, cur_weekday} = 33'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      rd(ri[k], v);
      `CHK("reset value", 8'h00, v)
      r = rnd();
      wr(ri[k], r[7:0]);
      rd(ri[k], v);
      `CHK("readback", r[7:0] & rm[k], v)
      `CHK("read upper bytes", 24'h000000, hrdata[31:8])
      `CHK("ready and okay", 2'h2, {hreadyout, hresp})
      wr(ri[k], 8'h00);
    end
    $display("test registers done");
    ac(8'h08, 32'h80808080, 1'b0, 32'h12340509, 7'h01);
    ac(8'h09, 32'h80808080, 1'b0, 32'h12340509, 7'h01);
    ac(8'h00, 32'h80808080, 1'b0, 32'h12340509, 7'h01);
    ac(8'h08, 32'h8000073e, 1'b0, 32'h37000709, 7'h02);
    ac(8'h08, 32'h8000073e, 1'b0, 32'h37000709, 7'h01);
    ac(8'h08, 32'h3059187f, 1'b0, 32'h30591801, 7'h10);
    ac(8'h08, 32'h00308041, 1'b0, 32'h00301309, 7'h40);
    ac(8'h08, 32'h00308015, 1'b1, 32'h00300515, 7'h01);
    ac(8'h08, 32'h00308015, 1'b1, 32'h00300514, 7'h01);
    for (int k = 0; k < 20; k++) begin
      r = rnd();
      t = {bcd(rnd() % 60), bcd(rnd() % 60), bcd(rnd() % 24), bcd(rnd() % 31 + 1)};
      a = t | {r[0], 7'h0, r[1], 7'h0, r[2], 7'h0, r[3], 7'h0};
      if (r[4]) a[22:16] = a[22:16] ^ 7'h01;
      if (!r[7]) a[6:0] = r[14:8];
      ac(r[6:5] == 2'h0 ? 8'h09 : 8'h08, a, r[7], t, 7'h01 << (rnd() % 7));
    end
    $display("test alarm done");
    uc(8'h20, 8'h00, 1'b0, 1'b1, RC - 1);
    uc(8'h20, 8'h20, 1'b0, 1'b0, 0);
    uc(8'h20, 8'h20, 1'b1, 1'b1, RC - 1);
    uc(8'h21, 8'h00, 1'b0, 1'b0, 0);
    uc(8'h00, 8'h00, 1'b0, 1'b1, 0);
    wr(CT, 8'h20);
    tick(1'b0);
    wr(FL, 8'h20);
    pin(1'b0);
    wr(FL, 8'h00);
    pin(1'b1);
    $display("test update done");
    wr(CT, 8'h10);
    timer_irq_req <= 1'b1;
    @(posedge clk);
    pin(1'b0);
    timer_irq_req <= 1'b0;
    @(posedge clk);
    pin(1'b1);
    wr(CT, 8'h00);
    $display("test timer done");
    final_report();
  end
endmodule
`default_nettype wire

/* File: core/alarm_compare.sv */
// =====================================================================
// Alarm comparator: current time against the four alarm fields.
// Assumes BCD time inputs and a one-hot weekday (bit 0 Sunday).
`timescale 1ns/1ns
`default_nettype none
module alarm_compare (
  input wire logic [7:0] sec_alarm,
  input wire logic [7:0] min_alarm,
  input wire logic [7:0] hour_alarm,
  input wire logic [7:0] week_day_alarm,
  input wire logic week_day_select,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_day,
  input wire logic [6:0] cur_weekday,
  output logic match
);

  logic sec_hit;
  logic min_hit;
  logic hour_hit;
  logic day_hit;
  logic week_hit;
  logic date_hit;

  // =====================================================================
  // Field comparison; an ignored field always hits
  assign sec_hit = rtc_irq_pkg::field_hit(sec_alarm[rtc_irq_pkg::BIT_FIELD_IGNORE],
    sec_alarm[6:0], cur_sec);
  assign min_hit = rtc_irq_pkg::field_hit(min_alarm[rtc_irq_pkg::BIT_FIELD_IGNORE],
    min_alarm[6:0], cur_min);
  assign hour_hit = rtc_irq_pkg::field_hit(hour_alarm[rtc_irq_pkg::BIT_FIELD_IGNORE],
    {1'b0, hour_alarm[5:0]}, {1'b0, cur_hour});
  assign date_hit = rtc_irq_pkg::field_hit(1'b0, {1'b0, week_day_alarm[5:0]},
    {1'b0, cur_day});
  // Any set weekday bit that matches today hits
  assign week_hit = |(week_day_alarm[6:0] & cur_weekday);
  // Week mode with select 0, day-of-month with select 1
  assign day_hit = week_day_alarm[rtc_irq_pkg::BIT_FIELD_IGNORE] ||
    (week_day_select ? date_hit : week_hit);

  assign match = sec_hit && min_hit && hour_hit && day_hit;

endmodule
`default_nettype wire

/* File: core/rtc_irq_core.sv */
// =====================================================================
// Alarm and time-update interrupt logic with its AHB-Lite registers.
// Assumes the time counters sit outside and give one-cycle tick pulses
// in the cycle after the time values change; the wake-up timer request
// comes from outside as a level.
`timescale 1ns/1ns
`default_nettype none
module rtc_irq_core #(
  parameter int unsigned RELEASE_CYCLES = rtc_irq_pkg::UPDATE_PULSE_RELEASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Time base from the clock counters
  input wire logic sec_tick,
  input wire logic min_tick,
  input wire logic [6:0] cur_sec,
  input wire logic [6:0] cur_min,
  input wire logic [5:0] cur_hour,
  input wire logic [5:0] cur_day,
  input wire logic [6:0] cur_weekday,
  // Wake-up timer request from outside
  input wire logic timer_irq_req,
  // Open-drain interrupt pin
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  // =====================================================================
  // Register state
  // Alarm settings keep all eight bits so software reads back what it wrote
  logic [7:0] sec_alarm_q;
  logic [7:0] min_alarm_q;
  logic [7:0] hour_alarm_q;
  logic [7:0] week_day_alarm_q;
  logic [7:0] extension_control_q;
  logic [7:0] interrupt_control_q;
  logic alarm_flag_q;
  logic update_flag_q;
  logic [31:0] hrdata_q;

  // Data-phase bookkeeping
  // A write's index is held one cycle, until its data arrives
  logic wr_pending_q;
  logic [5:0] wr_index_q;

  // Address-phase decode and the write byte of the data phase
  logic access;
  logic [5:0] addr_index;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  // Control bits
  logic week_day_select;
  logic update_period_select;
  logic update_irq_enable;
  logic timer_irq_enable;
  logic alarm_irq_enable;
  logic stop;

  // Events and requests
  logic alarm_match;
  logic alarm_event;
  logic update_event;
  logic update_window;
  logic alarm_req;
  logic update_req;
  logic timer_req;
  logic alarm_flag_clear;
  logic update_flag_clear;

  // =====================================================================
  // AHB-Lite address phase
  // Every transfer completes with no wait state and an OKAY response.
  assign access = hsel && hready && (htrans == rtc_irq_pkg::HTRANS_NONSEQ);
  assign addr_index = haddr[7:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Remember a write for the data phase that follows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pending_q <= 1'b0;
      wr_index_q <= '0;
    end else if (hready) begin
      wr_pending_q <= access && hwrite;
      wr_index_q <= addr_index;
    end
  end

  assign wr_en = wr_pending_q;
  // Only byte lane 0 carries register data. The transfer size is not
  // decoded: software is expected to use whole words, and a narrower
  // write still lands as if it were a word.
  assign wr_byte = hwdata[7:0];

  // =====================================================================
  // Read path
  // Read data is captured in the address phase so it stands from a
  // flip-flop through the whole data phase; unmapped indices read zero.
  always_comb begin
    rd_byte = 8'h00;
    unique case (addr_index)
      rtc_irq_pkg::IDX_SEC_ALARM: rd_byte = sec_alarm_q;
      rtc_irq_pkg::IDX_MIN_ALARM: rd_byte = min_alarm_q;
      rtc_irq_pkg::IDX_HOUR_ALARM: rd_byte = hour_alarm_q;
      rtc_irq_pkg::IDX_WEEK_DAY_ALARM: rd_byte = week_day_alarm_q;
      rtc_irq_pkg::IDX_EXTENSION_CONTROL: rd_byte = extension_control_q;
      rtc_irq_pkg::IDX_EVENT_FLAGS: begin
        rd_byte[rtc_irq_pkg::BIT_UPDATE_FLAG] = update_flag_q;
        rd_byte[rtc_irq_pkg::BIT_ALARM_FLAG] = alarm_flag_q;
      end
      rtc_irq_pkg::IDX_INTERRUPT_CONTROL: rd_byte = interrupt_control_q;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata_q <= '0;
    end else if (access && !hwrite) begin
      // Loaded only by an accepted read, so a write leaves old data standing
      hrdata_q <= {24'h000000, rd_byte};
    end
  end

  assign hrdata = hrdata_q;

  // =====================================================================
  // Alarm setting registers
  // Settings are not checked for legal BCD; a value that the time
  // counters can never show never matches, but bit 6 of the hour and day-of-month settings is not compared.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sec_alarm_q <= rtc_irq_pkg::RESET_ALARM;
      min_alarm_q <= rtc_irq_pkg::RESET_ALARM;
      hour_alarm_q <= rtc_irq_pkg::RESET_ALARM;
      week_day_alarm_q <= rtc_irq_pkg::RESET_ALARM;
    end else if (wr_en) begin
      if (wr_index_q == rtc_irq_pkg::IDX_SEC_ALARM) begin
        sec_alarm_q <= wr_byte;
      end
      if (wr_index_q == rtc_irq_pkg::IDX_MIN_ALARM) begin
        min_alarm_q <= wr_byte;
      end
      if (wr_index_q == rtc_irq_pkg::IDX_HOUR_ALARM) begin
        hour_alarm_q <= wr_byte;
      end
      if (wr_index_q == rtc_irq_pkg::IDX_WEEK_DAY_ALARM) begin
        week_day_alarm_q <= wr_byte;
      end
    end
  end

  // =====================================================================
  // Control registers
  // Bits that belong to other functions are kept as plain storage.
  // A cleared enable reaches the pin as soon as the write lands, with no extra cycle.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      extension_control_q <= rtc_irq_pkg::RESET_EXTENSION_CONTROL;
    end else if (wr_en && (wr_index_q == rtc_irq_pkg::IDX_EXTENSION_CONTROL)) begin
      extension_control_q <= wr_byte & rtc_irq_pkg::MASK_EXTENSION_CONTROL;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      interrupt_control_q <= rtc_irq_pkg::RESET_INTERRUPT_CONTROL;
    end else if (wr_en && (wr_index_q == rtc_irq_pkg::IDX_INTERRUPT_CONTROL)) begin
      interrupt_control_q <= wr_byte & rtc_irq_pkg::MASK_INTERRUPT_CONTROL;
    end
  end

  assign week_day_select = extension_control_q[rtc_irq_pkg::BIT_WEEK_DAY_SELECT];
  assign update_period_select = extension_control_q[rtc_irq_pkg::BIT_UPDATE_PERIOD_SELECT];
  assign update_irq_enable = interrupt_control_q[rtc_irq_pkg::BIT_UPDATE_IRQ_ENABLE];
  assign timer_irq_enable = interrupt_control_q[rtc_irq_pkg::BIT_TIMER_IRQ_ENABLE];
  assign alarm_irq_enable = interrupt_control_q[rtc_irq_pkg::BIT_ALARM_IRQ_ENABLE];
  assign stop = interrupt_control_q[rtc_irq_pkg::BIT_STOP];

  // =====================================================================
  // Alarm event
  // Pure comparison; when an event may fire is decided here, not inside
  alarm_compare u_alarm_compare (
    .sec_alarm(sec_alarm_q),
    .min_alarm(min_alarm_q),
    .hour_alarm(hour_alarm_q),
    .week_day_alarm(week_day_alarm_q),
    .week_day_select(week_day_select),
    .cur_sec(cur_sec),
    .cur_min(cur_min),
    .cur_hour(cur_hour),
    .cur_day(cur_day),
    .cur_weekday(cur_weekday),
    .match(alarm_match)
  );

  // Sampled only on the seconds tick, so writing a setting equal to the
  // present time fires nothing until the next updated time matches.
  // Stop blocks events even if the outside counters still tick.
  assign alarm_event = sec_tick && alarm_match && !stop;

  // =====================================================================
  // Update event
  // The generator runs regardless of the enable; only the pin is gated.
  // The release window restarts on every event; with the real window
  // far shorter than a second, consecutive pulses never merge, but a
  // shortened window in simulation must still stay below the tick gap.
  assign update_event = !stop &&
    (update_period_select ? min_tick : sec_tick);

  // Window length is a parameter so a bench can shorten it
  update_release_timer #(
    .RELEASE_CYCLES(RELEASE_CYCLES)
  ) u_update_release_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(update_event),
    .active(update_window)
  );

  // =====================================================================
  // Event flags
  // Only a written 0 clears; a written 1 leaves the flag alone, and an
  // event in the clearing cycle wins so it is never lost.
  assign alarm_flag_clear = wr_en && (wr_index_q == rtc_irq_pkg::IDX_EVENT_FLAGS) &&
    !wr_byte[rtc_irq_pkg::BIT_ALARM_FLAG];
  assign update_flag_clear = wr_en && (wr_index_q == rtc_irq_pkg::IDX_EVENT_FLAGS) &&
    !wr_byte[rtc_irq_pkg::BIT_UPDATE_FLAG];

  // Alarm flag latches whether or not the pin is enabled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alarm_flag_q <= 1'b0;
    end else if (alarm_event) begin
      alarm_flag_q <= 1'b1;
    end else if (alarm_flag_clear) begin
      alarm_flag_q <= 1'b0;
    end
  end

  // Update flag follows the same set-wins rule as the alarm flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      update_flag_q <= 1'b0;
    end else if (update_event) begin
      update_flag_q <= 1'b1;
    end else if (update_flag_clear) begin
      update_flag_q <= 1'b0;
    end
  end

  // =====================================================================
  // Interrupt pin
  // Requests are gated combinationally so a cleared enable or flag
  // releases the pin at once rather than one cycle late.
  assign alarm_req = alarm_flag_q && alarm_irq_enable;
  assign update_req = update_flag_q && update_window && update_irq_enable;
  assign timer_req = timer_irq_req && timer_irq_enable;

  // Pin is only ever driven low; enable low means driving
  // The value is tied low and only the enable moves, so the pin never
  // drives high and the outside pull-up sets the released level.
  assign irq_n_out = 1'b0;
  assign irq_n_oe_n = !(alarm_req || update_req || timer_req);

endmodule
`default_nettype wire

/* File: core/rtc_irq_pkg.sv */
// =====================================================================
// Shared constants for the alarm and time-update interrupt logic.
// Assumes a 100 MHz system clock and 32-bit AHB-Lite register access.
`default_nettype none
package rtc_irq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SEC_ALARM = 6'h06;
  localparam logic [5:0] IDX_MIN_ALARM = 6'h07;
  localparam logic [5:0] IDX_HOUR_ALARM = 6'h08;
  localparam logic [5:0] IDX_WEEK_DAY_ALARM = 6'h09;
  localparam logic [5:0] IDX_EXTENSION_CONTROL = 6'h0d;
  localparam logic [5:0] IDX_EVENT_FLAGS = 6'h0e;
  localparam logic [5:0] IDX_INTERRUPT_CONTROL = 6'h0f;

  // Field positions
  localparam int unsigned BIT_FIELD_IGNORE = 7;
  localparam int unsigned BIT_UPDATE_PERIOD_SELECT = 5;
  localparam int unsigned BIT_WEEK_DAY_SELECT = 3;
  localparam int unsigned BIT_UPDATE_FLAG = 5;
  localparam int unsigned BIT_ALARM_FLAG = 3;
  localparam int unsigned BIT_UPDATE_IRQ_ENABLE = 5;
  localparam int unsigned BIT_TIMER_IRQ_ENABLE = 4;
  localparam int unsigned BIT_ALARM_IRQ_ENABLE = 3;
  localparam int unsigned BIT_STOP = 0;

  // Writable bits of the control registers; the rest read as zero
  localparam logic [7:0] MASK_EXTENSION_CONTROL = 8'hfb;
  localparam logic [7:0] MASK_INTERRUPT_CONTROL = 8'h3d;

  // Reset values
  localparam logic [7:0] RESET_ALARM = 8'h00;
  localparam logic [7:0] RESET_EXTENSION_CONTROL = 8'h00;
  localparam logic [7:0] RESET_INTERRUPT_CONTROL = 8'h00;

  // Update pulse release window and its cycle count (least time, rounded up)
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned UPDATE_PULSE_RELEASE_TIME_MIN_NS = 7324000;
  localparam int unsigned UPDATE_PULSE_RELEASE_TIME_MAX_NS = 7644000;
  localparam int unsigned UPDATE_PULSE_RELEASE_CYCLES =
    (UPDATE_PULSE_RELEASE_TIME_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_COUNT_WIDTH = 20;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // One alarm field: ignored, or equal to the current value
  function automatic logic field_hit(input logic ignore, input logic [6:0] alarm,
                                     input logic [6:0] now);
    field_hit = ignore || (alarm == now);
  endfunction

endpackage
`default_nettype wire

/* File: core/update_release_timer.sv */
// =====================================================================
// Release timer for the update interrupt low pulse.
// Assumes start is a one-cycle pulse on each time update event.
`timescale 1ns/1ns
`default_nettype none
module update_release_timer #(
  parameter int unsigned RELEASE_CYCLES = rtc_irq_pkg::UPDATE_PULSE_RELEASE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  output logic active
);

  localparam int unsigned CNT_W = rtc_irq_pkg::RELEASE_COUNT_WIDTH;
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(RELEASE_CYCLES);
  localparam logic [CNT_W-1:0] ZERO = '0;
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  logic [CNT_W-1:0] count_q;

  // =====================================================================
  // Count down from the load value; a new event restarts the window
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= ZERO;
    end else if (start) begin
      count_q <= LOAD;
    end else if (count_q != ZERO) begin
      count_q <= count_q - ONE;
    end
  end

  assign active = (count_q != ZERO);

endmodule
`default_nettype wire
